// >>> acms_consts.vh
// constants for the ac-link modem status and access lock block
`ifndef ACMS_CONSTS_VH
`define ACMS_CONSTS_VH
// ============================================================
// register offsets within the bus master io window
`define ACMS_OFS_STATUS 8'h40
`define ACMS_OFS_LOCK 8'h44
// ============================================================
// status bit positions
`define ACMS_B_RCS 15
`define ACMS_B_S1RES 11
`define ACMS_B_S0RES 10
`define ACMS_B_S1RDY 9
`define ACMS_B_S0RDY 8
`define ACMS_B_MIC 7
`define ACMS_B_POUT 6
`define ACMS_B_PIN 5
`define ACMS_B_MOUT 2
`define ACMS_B_MIN 1
`define ACMS_B_GPI 0
`define ACMS_B_LOCK 0
// ============================================================
// reset values and timing
`define ACMS_LOCK_RST 8'h00
`define ACMS_TIMEOUT_FRAMES 3'h4
`define ACMS_DUMMY_DATA 16'hFFFF
`endif

// >>> acms_status_lock.v
// global link status low half, codec access lock and codec read time-out
`include "acms_consts.vh"
module acms_status_lock (
    input wire clk,
    input wire rst,
    input wire func_rst,
    input wire rd_en,
    input wire wr_en,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire [3:0] wbe,
    output reg [31:0] rdata,
    output reg rvalid,
    input wire bit_clk,
    input wire sync_pin,
    input wire sdi0_ready,
    input wire sdi1_ready,
    input wire sdi0_resume,
    input wire sdi1_resume,
    input wire slot12_valid,
    input wire [3:0] slot12_bits,
    input wire mic_in_chan_irq,
    input wire pcm_out_chan_irq,
    input wire pcm_in_chan_irq,
    input wire modem_out_chan_irq,
    input wire modem_in_chan_irq,
    input wire codec_rd_start,
    input wire codec_acc_done,
    input wire codec_rd_resp,
    input wire [15:0] codec_rd_data,
    output reg codec_rd_cpl,
    output reg [15:0] codec_rd_cpl_data,
    output reg codec_rd_timeout
);
    // ============================================================
    // pin synchronisers
    reg [1:0] bclk_s;
    reg [1:0] sync_s;
    reg [1:0] rdy0_s;
    reg [1:0] rdy1_s;
    reg [1:0] res0_s;
    reg [1:0] res1_s;
    reg [1:0] s12v_s;
    reg [3:0] s12a_r;
    reg [3:0] s12b_r;
    reg bclk_d_r;
    reg sync_d_r;
    reg res0_d_r;
    reg res1_d_r;
    reg s12v_d_r;
    wire bclk_rise;
    wire frame_start;
    wire res0_evt;
    wire res1_evt;
    wire s12_evt;
    // two-flop synchronisers, first stage read only by second
    always @(posedge clk) begin
        if (rst) begin
            bclk_s <= 2'h0;
            sync_s <= 2'h0;
            rdy0_s <= 2'h0;
            rdy1_s <= 2'h0;
            res0_s <= 2'h0;
            res1_s <= 2'h0;
            s12v_s <= 2'h0;
            s12a_r <= 4'h0;
            s12b_r <= 4'h0;
        end else begin
            bclk_s <= {bclk_s[0], bit_clk};
            sync_s <= {sync_s[0], sync_pin};
            rdy0_s <= {rdy0_s[0], sdi0_ready};
            rdy1_s <= {rdy1_s[0], sdi1_ready};
            res0_s <= {res0_s[0], sdi0_resume};
            res1_s <= {res1_s[0], sdi1_resume};
            s12v_s <= {s12v_s[0], slot12_valid};
            s12a_r <= slot12_bits;
            s12b_r <= s12a_r;
        end
    end
    // edge detectors on synchronised signals
    always @(posedge clk) begin
        if (rst) begin
            bclk_d_r <= 1'b0;
            sync_d_r <= 1'b0;
            res0_d_r <= 1'b0;
            res1_d_r <= 1'b0;
            s12v_d_r <= 1'b0;
        end else begin
            bclk_d_r <= bclk_s[1];
            sync_d_r <= sync_s[1];
            res0_d_r <= res0_s[1];
            res1_d_r <= res1_s[1];
            s12v_d_r <= s12v_s[1];
        end
    end
    assign bclk_rise = bclk_s[1] & ~bclk_d_r;
    assign frame_start = sync_s[1] & ~sync_d_r;
    assign res0_evt = res0_s[1] & ~res0_d_r;
    assign res1_evt = res1_s[1] & ~res1_d_r;
    assign s12_evt = s12v_s[1] & ~s12v_d_r;
    // ============================================================
    // register access decode
    wire st_rd = rd_en & (addr == `ACMS_OFS_STATUS);
    wire st_wr = wr_en & (addr == `ACMS_OFS_STATUS);
    wire lk_rd = rd_en & (addr == `ACMS_OFS_LOCK);
    wire clr_lo = st_wr & wbe[0];
    wire clr_hi = st_wr & wbe[1];
    // ============================================================
    // sticky flags, set wins over write-one clear
    reg s0_res_r;
    reg s1_res_r;
    reg gpi_chg_r;
    reg rcs_r;
    reg [2:0] slot12_hi_r;
    reg timeout_evt;
    // cleared by full reset or write-one clear, never by func_rst
    always @(posedge clk) begin
        if (rst) begin
            s0_res_r <= 1'b0;
            s1_res_r <= 1'b0;
            gpi_chg_r <= 1'b0;
            rcs_r <= 1'b0;
            slot12_hi_r <= 3'h0;
        end else begin
            s0_res_r <= res0_evt | (s0_res_r & ~(clr_hi & wdata[`ACMS_B_S0RES]));
            s1_res_r <= res1_evt | (s1_res_r & ~(clr_hi & wdata[`ACMS_B_S1RES]));
            gpi_chg_r <= (s12_evt & s12b_r[0])
                | (gpi_chg_r & ~(clr_lo & wdata[`ACMS_B_GPI]));
            rcs_r <= timeout_evt | (rcs_r & ~(clr_hi & wdata[`ACMS_B_RCS]));
            if (s12_evt) begin
                slot12_hi_r <= s12b_r[3:1];
            end
        end
    end
    // ============================================================
    // codec access lock
    reg lock_r;
    // read sets the lock; access completion clears it
    always @(posedge clk) begin
        if (rst || func_rst) begin
            lock_r <= 1'b0;
        end else if (lk_rd) begin
            lock_r <= 1'b1;
        end else if (codec_acc_done || timeout_evt) begin
            lock_r <= 1'b0;
        end
    end
    // ============================================================
    // codec read time-out in frames
    localparam RD_IDLE = 1'b0;
    localparam RD_WAIT = 1'b1;
    reg rd_state_r;
    reg [2:0] frame_cnt_r;
    // counts frame starts seen on the link while waiting
    always @(posedge clk) begin
        if (rst || func_rst) begin
            rd_state_r <= RD_IDLE;
            frame_cnt_r <= 3'h0;
            codec_rd_cpl <= 1'b0;
            codec_rd_cpl_data <= 16'h0000;
            codec_rd_timeout <= 1'b0;
            timeout_evt <= 1'b0;
        end else begin
            codec_rd_cpl <= 1'b0;
            codec_rd_timeout <= 1'b0;
            timeout_evt <= 1'b0;
            case (rd_state_r)
                RD_IDLE: begin
                    frame_cnt_r <= 3'h0;
                    if (codec_rd_start) begin
                        rd_state_r <= RD_WAIT;
                    end
                end
                RD_WAIT: begin
                    if (codec_rd_resp) begin
                        codec_rd_cpl <= 1'b1;
                        codec_rd_cpl_data <= codec_rd_data;
                        rd_state_r <= RD_IDLE;
                    end else if (frame_start && bclk_s[1]
                            && frame_cnt_r == `ACMS_TIMEOUT_FRAMES - 3'h1) begin
                        codec_rd_cpl <= 1'b1;
                        codec_rd_cpl_data <= `ACMS_DUMMY_DATA;
                        codec_rd_timeout <= 1'b1;
                        timeout_evt <= 1'b1;
                        rd_state_r <= RD_IDLE;
                    end else if (frame_start) begin
                        frame_cnt_r <= frame_cnt_r + 3'h1;
                    end
                end
                default: rd_state_r <= RD_IDLE;
            endcase
        end
    end
    // ============================================================
    // read data; ready and summary bits are live mirrors
    reg [31:0] st_word;
    always @* begin
        st_word = 32'h0000_0000;
        st_word[`ACMS_B_RCS] = rcs_r;
        st_word[14:12] = slot12_hi_r;
        st_word[`ACMS_B_S1RES] = s1_res_r;
        st_word[`ACMS_B_S0RES] = s0_res_r;
        st_word[`ACMS_B_S1RDY] = rdy1_s[1];
        st_word[`ACMS_B_S0RDY] = rdy0_s[1];
        // channel summaries are status only; no dma path waits on codec ready
        st_word[`ACMS_B_MIC] = mic_in_chan_irq;
        st_word[`ACMS_B_POUT] = pcm_out_chan_irq;
        st_word[`ACMS_B_PIN] = pcm_in_chan_irq;
        st_word[`ACMS_B_MOUT] = modem_out_chan_irq;
        st_word[`ACMS_B_MIN] = modem_in_chan_irq;
        st_word[`ACMS_B_GPI] = gpi_chg_r;
    end
    // registered read answer one cycle after the strobe
    always @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
            rvalid <= 1'b0;
        end else begin
            rvalid <= rd_en;
            if (st_rd) begin
                rdata <= st_word;
            end else if (lk_rd) begin
                rdata <= {24'h000000, 7'h00, lock_r};
            end else begin
                rdata <= 32'h0000_0000;
            end
        end
    end
    // bclk_rise is kept for frame sampling by later users
    wire unused_ok = bclk_rise;
endmodule // acms_status_lock

// >>> acms_status_lock_sva.sv
// port checker for the status and access lock block
module acms_status_lock_sva (
    input wire clk, input wire rst, input wire rd_en, input wire [7:0] addr,
    input wire [31:0] rdata, input wire sdi0_ready, input wire mic_in_chan_irq,
    input wire pcm_out_chan_irq, input wire pcm_in_chan_irq, input wire modem_out_chan_irq,
    input wire modem_in_chan_irq, input wire codec_rd_start, input wire codec_acc_done,
    input wire codec_rd_cpl, input wire [15:0] codec_rd_cpl_data, input wire codec_rd_timeout
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // status reads at 0x40, lock reads at 0x44
    wire st = rd_en && addr == 8'h40;
    wire lk = rd_en && addr == 8'h44;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_audio_sum: assert property (st |=> rdata[7:5] ==
        $past({mic_in_chan_irq, pcm_out_chan_irq, pcm_in_chan_irq})) else $error("audio sum");
    a_modem_sum: assert property (st |=> rdata[2:1] ==
        $past({modem_out_chan_irq, modem_in_chan_irq})) else $error("modem sum");
    a_ready_mirror: assert property (st && sdi0_ready && $past(sdi0_ready, 2)
        && $past(sdi0_ready, 4) |=> rdata[8]) else $error("ready mirror");
    a_lock_grant: assert property (lk ##1 !codec_acc_done ##1 lk
        |=> rdata[0]) else $error("lock grant");
    a_lock_free: assert property (codec_acc_done ##1 !rd_en ##1 lk
        |=> !rdata[0]) else $error("lock free");
    a_unmapped_zero: assert property (rd_en && addr != 8'h40 && addr != 8'h44
        |=> rdata == 32'h0) else $error("unmapped");
    a_dummy_ones: assert property (codec_rd_timeout |-> codec_rd_cpl
        && codec_rd_cpl_data == 16'hFFFF) else $error("dummy data");
    a_read_bound: assert property (codec_rd_start |-> ##[1:600] codec_rd_cpl)
        else $error("no completion");
    cover property (codec_rd_timeout);
    cover property (codec_rd_cpl && !codec_rd_timeout);
    cover property (lk ##2 lk);
endmodule // acms_status_lock_sva
bind acms_status_lock acms_status_lock_sva u_sva (.*);

// >>> acms_codec_model.sv
// codec stand-in: bit clock, frame sync and delayed read answers
module acms_codec_model (
    input wire clk, input wire start, input wire [2:0] frames, input wire [15:0] val,
    output logic bit_clk, output logic sync_pin, output logic resp, output wire [15:0] data
);
    timeunit 1ns;
    timeprecision 100ps;
    int n = 0;
    int w = -1;
    logic sp = 1'b0;
    // ==========
    // 64 ns bit clock, sync high one bit clock in eight
    initial begin
        {bit_clk, sync_pin, resp} = 3'h0;
        forever #32 bit_clk = ~bit_clk;
    end
    always @(posedge bit_clk) begin
        n <= (n + 1) % 8;
        sync_pin <= n == 0;
    end
    // answer after the chosen count of frame starts; idle data is inverted
    always @(posedge clk) begin
        sp <= sync_pin;
        resp <= w == 0;
        if (start) w <= int'(frames);
        else if (w == 0) w <= -1;
        else if (w > 0 && sync_pin && !sp) w <= w - 1;
    end
    assign data = resp ? val : ~val;
endmodule // acms_codec_model

// >>> acms_status_lock_tb.sv
// self-checking bench for the status and access lock block
module acms_status_lock_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, func_rst = 0, rd_en = 0, wr_en = 0, sdi0_ready = 0, sdi1_ready = 0;
    logic sdi0_resume = 0, sdi1_resume = 0, slot12_valid = 0, codec_rd_start = 0;
    logic codec_acc_done = 0, mic_in_chan_irq = 0, pcm_out_chan_irq = 0, pcm_in_chan_irq = 0;
    logic modem_out_chan_irq = 0, modem_in_chan_irq = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, r = 32'h0, exp_q[$], msk_q[$];
    logic [3:0] wbe = 4'h0, slot12_bits = 4'h0;
    logic [2:0] frames = 3'h1;
    logic [16:0] cpl_q[$];
    wire [31:0] rdata;
    wire [15:0] codec_rd_data, codec_rd_cpl_data;
    wire rvalid, bit_clk, sync_pin, codec_rd_resp, codec_rd_cpl, codec_rd_timeout;
    int mismatches = 0, check_count = 0;
    acms_status_lock u_dut (.*);
    acms_codec_model u_codec (.clk(clk), .start(codec_rd_start), .frames(frames),
        .val(r[15:0]), .bit_clk(bit_clk), .sync_pin(sync_pin), .resp(codec_rd_resp),
        .data(codec_rd_data));
    initial forever #2 clk = ~clk;
    // ==========
    // compares, bus cycles and strobes
    task automatic cmp_reg(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin mismatches++; $display("Error %0t got %h exp %h", $time, g, e); end
    endtask
    task automatic cmp_cpl(input logic [16:0] g, e);
        check_count++;
        if (g !== e) begin mismatches++; $display("Error %0t got %h exp %h", $time, g, e); end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        tick(1); addr = a; rd_en = 1; exp_q.push_back(e); msk_q.push_back(m);
        tick(1); rd_en = 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        tick(1); addr = a; wdata = d; wbe = b; wr_en = 1;
        tick(1); wr_en = 0;
    endtask
    task automatic done_pulse;
        tick(1); codec_acc_done = 1; tick(1); codec_acc_done = 0;
    endtask
    task automatic go(input logic [16:0] e);
        cpl_q.push_back(e);
        tick(1); codec_rd_start = 1; tick(1); codec_rd_start = 0;
        for (int i = 0; i < 700 && codec_rd_cpl !== 1'b1; i++) tick(1);
        tick(1);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // scoreboard: each answer against the oldest note
    always @(posedge clk) begin
        if (rvalid === 1'b1) cmp_reg(rdata & msk_q.pop_front(), exp_q.pop_front());
        if (codec_rd_cpl === 1'b1)
            cmp_cpl({codec_rd_timeout, codec_rd_cpl_data}, cpl_q.pop_front());
    end
    // watchdog
    initial begin
        #100000;
        mismatches++;
        complete_run;
    end
    // main sequence
    initial begin
        void'($urandom(32'h3b122bf6));
        tick(4); rst = 0;
        rd(8'h44, 32'h0, 32'hFF);
        rd(8'h44, 32'h1, 32'hFF);
        done_pulse; rd(8'h44, 32'h0, 32'h1);
        done_pulse; rd(8'h4C, 32'h0, 32'hFFFFFFFF);
        r = $urandom; sdi0_ready = 1; sdi1_ready = r[0];
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            {mic_in_chan_irq, pcm_out_chan_irq, pcm_in_chan_irq, modem_out_chan_irq,
                modem_in_chan_irq} = r[4:0];
            tick(4);
            rd(8'h40, {22'h0, sdi1_ready, 1'b1, r[4:2], 2'h0, r[1:0], 1'b0},
                32'h3E6);
        end
        slot12_bits = 4'hB; {sdi0_resume, sdi1_resume, slot12_valid} = 3'h7; tick(8);
        {sdi0_resume, sdi1_resume, slot12_valid} = 3'h0; tick(8);
        func_rst = 1; tick(2); func_rst = 0;
        rd(8'h40, 32'h5C01, 32'hFC01);
        wr(8'h40, 32'h401, 4'h3); rd(8'h40, 32'h5800, 32'hFC01);
        rd(8'h44, 32'h0, 32'h1); r = $urandom; go({1'b0, r[15:0]});
        rd(8'h40, 32'h0, 32'h8000); done_pulse; frames = 3'h7;
        rd(8'h44, 32'h0, 32'h1); go({1'b1, 16'hFFFF});
        rd(8'h40, 32'h8000, 32'h8000);
        rd(8'h44, 32'h0, 32'h1);
        wr(8'h40, 32'h8000, 4'h2); rd(8'h40, 32'h0, 32'h8000);
        tick(3); cmp_reg(32'(exp_q.size() + cpl_q.size()), 32'h0);
        complete_run;
    end
endmodule // acms_status_lock_tb
